// >>> logic/mcpie_exec.sv
// Purpose: execute slice for interrupt gate, watchdog stop, power-down arm
//   and port input instructions of a 4-bit core
// Assumes: CLK is the machine-cycle clock, one instruction per cycle
// Notes: APB registers give status, accumulator and a control word
//
// Contract
// - the mask instruction clears the gate, and acceptance drops one cycle later.
// - the unmask instruction sets the gate, and acceptance rises one cycle later.
// - the watchdog stop arm instruction only grants permission to halt.
// - a kick with permission granted halts the watchdog instead of restarting it.
// - power-down words act only as the next executed word after the power-down arm word.
// - read pin bit puts the pin in acc bit 0 and zeros bits 3 to 1.
// - read port zero loads all four acc bits from the first nibble port.
// - read port one loads all four acc bits from the second nibble port.
// - read port two puts its two pins in acc bits 1 and 0, zeroing 3 and 2.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
module mcpie_exec #(
	parameter logic [9:0] OP_IRQ_MASK = mcpie_pkg::DEF_IRQ_MASK,
	parameter logic [9:0] OP_WDT_KICK = mcpie_pkg::DEF_WDT_KICK,
	parameter logic [9:0] OP_PD = mcpie_pkg::DEF_PD,
	parameter logic [9:0] OP_DEEP_PD = mcpie_pkg::DEF_DEEP_PD
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic INSTR_VALID,
	input wire logic [9:0] INSTR,
	input wire logic PIN_BIT,
	input wire logic [3:0] FIRST_NIBBLE_PORT,
	input wire logic [3:0] SECOND_NIBBLE_PORT,
	input wire logic [1:0] TWO_BIT_PORT,
	output logic [3:0] ACC,
	output logic ACC_LOAD,
	output logic IRQ_GLOBAL_GATE,
	output logic IRQ_ACCEPT,
	output logic WDT_STOP_PERMIT,
	output logic WDT_HALT,
	output logic WDT_RESTART,
	output logic PD_REQ,
	output logic DEEP_PD_REQ,
	output logic INSTR_DONE,
	output logic CARRY_WE,
	output logic SKIP_NEXT,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	// ==========================================================
	// elaboration checks
	generate
		if (OP_IRQ_MASK == mcpie_pkg::OP_IRQ_UNMASK ||
			OP_WDT_KICK == mcpie_pkg::OP_WDT_STOP_ARM ||
			OP_PD == mcpie_pkg::OP_PD_ARM ||
			OP_DEEP_PD == mcpie_pkg::OP_PD_ARM ||
			OP_PD == OP_DEEP_PD) begin : g_chk
			$error("mcpie_exec instruction codes collide");
		end
	endgenerate

	// ==========================================================
	// pin synchronisers
	logic [mcpie_pkg::SYNC_W-1:0] pins_raw;
	logic [mcpie_pkg::SYNC_W-1:0] pins;
	logic pin_bit_s;
	logic [3:0] nib0_s;
	logic [3:0] nib1_s;
	logic [1:0] two_s;

	assign pins_raw = {PIN_BIT, FIRST_NIBBLE_PORT, SECOND_NIBBLE_PORT,
		TWO_BIT_PORT};

	mcpie_sync #(
		.WIDTH(mcpie_pkg::SYNC_W)
	) u_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.din(pins_raw),
		.dout(pins)
	);

	assign pin_bit_s = pins[10];
	assign nib0_s = pins[9:6];
	assign nib1_s = pins[5:2];
	assign two_s = pins[1:0];

	// ==========================================================
	// control register
	logic [1:0] ctrl;
	logic [1:0] next_ctrl;
	logic wr_ctrl;
	logic exec;

	assign wr_ctrl = CE & PSEL & PENABLE & PWRITE &
		(PADDR == mcpie_pkg::REG_CTRL);
	// instructions are ignored while software holds execution off
	assign exec = INSTR_VALID & ctrl[mcpie_pkg::CT_EXEC_EN];

	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = PWDATA[1:0];
		end else if (CE) begin
			// resume is a self-clearing strobe
			next_ctrl[mcpie_pkg::CT_WDT_RESUME] = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ctrl <= mcpie_pkg::CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// ==========================================================
	// instruction decode
	logic is_mask;
	logic is_unmask;
	logic is_stop_arm;
	logic is_kick;
	logic is_pd_arm;
	logic is_pd;
	logic is_deep_pd;
	logic is_rd_bit;
	logic is_rd_p0;
	logic is_rd_p1;
	logic is_rd_p2;
	logic is_known;

	assign is_mask = exec & (INSTR == OP_IRQ_MASK);
	assign is_unmask = exec & (INSTR == mcpie_pkg::OP_IRQ_UNMASK);
	assign is_stop_arm = exec & (INSTR == mcpie_pkg::OP_WDT_STOP_ARM);
	assign is_kick = exec & (INSTR == OP_WDT_KICK);
	assign is_pd_arm = exec & (INSTR == mcpie_pkg::OP_PD_ARM);
	assign is_pd = exec & (INSTR == OP_PD);
	assign is_deep_pd = exec & (INSTR == OP_DEEP_PD);
	assign is_rd_bit = exec & (INSTR == mcpie_pkg::OP_READ_PIN_BIT);
	assign is_rd_p0 = exec & (INSTR == mcpie_pkg::OP_READ_PORT_ZERO);
	assign is_rd_p1 = exec & (INSTR == mcpie_pkg::OP_READ_PORT_ONE);
	assign is_rd_p2 = exec & (INSTR == mcpie_pkg::OP_READ_PORT_TWO);
	assign is_known = is_mask | is_unmask | is_stop_arm | is_kick |
		is_pd_arm | is_pd | is_deep_pd | is_rd_bit | is_rd_p0 |
		is_rd_p1 | is_rd_p2;

	// ==========================================================
	// interrupt gate and delayed acceptance
	logic gate;
	logic accept;
	logic next_gate;
	logic next_accept;

	always_comb begin
		next_gate = gate;
		next_accept = accept;
		if (CE) begin
			// acceptance trails the flag by one machine cycle
			next_accept = gate;
			if (is_mask) begin
				next_gate = 1'b0;
			end else if (is_unmask) begin
				next_gate = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			gate <= 1'b0;
			accept <= 1'b0;
		end else begin
			gate <= next_gate;
			accept <= next_accept;
		end
	end

	// ==========================================================
	// watchdog stop permission and halt
	logic permit;
	logic halt;
	logic restart;
	logic next_permit;
	logic next_halt;
	logic next_restart;

	always_comb begin
		next_permit = permit;
		next_halt = halt;
		next_restart = 1'b0;
		if (CE) begin
			if (ctrl[mcpie_pkg::CT_WDT_RESUME]) begin
				next_halt = 1'b0;
			end
			if (is_stop_arm) begin
				next_permit = 1'b1;
			end else if (is_kick && permit) begin
				// hardware set wins over a software resume
				next_halt = 1'b1;
				next_permit = 1'b0;
			end else if (is_kick) begin
				next_restart = 1'b1;
			end
		end else begin
			next_restart = restart;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			permit <= 1'b0;
			halt <= 1'b0;
			restart <= 1'b0;
		end else begin
			permit <= next_permit;
			halt <= next_halt;
			restart <= next_restart;
		end
	end

	// ==========================================================
	// power-down arming
	logic pd_armed;
	logic pd_req;
	logic deep_req;
	logic next_pd_armed;
	logic next_pd_req;
	logic next_deep_req;

	always_comb begin
		next_pd_armed = pd_armed;
		next_pd_req = pd_req;
		next_deep_req = deep_req;
		if (CE) begin
			next_pd_req = is_pd & pd_armed;
			next_deep_req = is_deep_pd & pd_armed;
			// any executed word consumes the arm, so it lasts one word only
			if (exec) begin
				next_pd_armed = is_pd_arm;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pd_armed <= 1'b0;
			pd_req <= 1'b0;
			deep_req <= 1'b0;
		end else begin
			pd_armed <= next_pd_armed;
			pd_req <= next_pd_req;
			deep_req <= next_deep_req;
		end
	end

	// ==========================================================
	// accumulator loads from the ports
	logic [3:0] acc;
	logic acc_load;
	logic done;
	logic [3:0] next_acc;
	logic next_acc_load;
	logic next_done;

	always_comb begin
		next_acc = acc;
		next_acc_load = acc_load;
		next_done = done;
		if (CE) begin
			next_acc_load = is_rd_bit | is_rd_p0 | is_rd_p1 | is_rd_p2;
			next_done = is_known;
			if (is_rd_bit) begin
				next_acc = {3'h0, pin_bit_s};
			end else if (is_rd_p0) begin
				next_acc = nib0_s;
			end else if (is_rd_p1) begin
				next_acc = nib1_s;
			end else if (is_rd_p2) begin
				next_acc = {2'h0, two_s};
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			acc <= 4'h0;
			acc_load <= 1'b0;
			done <= 1'b0;
		end else begin
			acc <= next_acc;
			acc_load <= next_acc_load;
			done <= next_done;
		end
	end

	// ==========================================================
	// APB slave, PREADY follows CE, so zero wait states while CE is high
	logic [31:0] rdata;
	logic slverr;
	logic [31:0] next_rdata;
	logic next_slverr;
	logic mapped;

	assign mapped = (PADDR == mcpie_pkg::REG_STATUS) |
		(PADDR == mcpie_pkg::REG_ACC) | (PADDR == mcpie_pkg::REG_CTRL);

	always_comb begin
		next_rdata = rdata;
		next_slverr = slverr;
		if (CE && PSEL) begin
			// captured in both phases; address is stable so data is too
			next_slverr = ~mapped;
			next_rdata = 32'h0;
			case (PADDR)
				mcpie_pkg::REG_STATUS: begin
					next_rdata[mcpie_pkg::ST_GATE] = gate;
					next_rdata[mcpie_pkg::ST_ACCEPT] = accept;
					next_rdata[mcpie_pkg::ST_WDT_PERMIT] = permit;
					next_rdata[mcpie_pkg::ST_WDT_HALT] = halt;
					next_rdata[mcpie_pkg::ST_PD_ARMED] = pd_armed;
				end
				mcpie_pkg::REG_ACC: begin
					next_rdata[3:0] = acc;
				end
				mcpie_pkg::REG_CTRL: begin
					next_rdata[1:0] = ctrl;
				end
				default: begin
					next_rdata = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rdata <= 32'h0;
			slverr <= 1'b0;
		end else begin
			rdata <= next_rdata;
			slverr <= next_slverr;
		end
	end

	// ==========================================================
	// outputs
	assign ACC = acc;
	assign ACC_LOAD = acc_load;
	assign IRQ_GLOBAL_GATE = gate;
	assign IRQ_ACCEPT = accept;
	assign WDT_STOP_PERMIT = permit;
	assign WDT_HALT = halt;
	assign WDT_RESTART = restart;
	assign PD_REQ = pd_req;
	assign DEEP_PD_REQ = deep_req;
	assign INSTR_DONE = done;
	// none of these words touch carry or skip
	assign CARRY_WE = 1'b0;
	assign SKIP_NEXT = 1'b0;
	assign PRDATA = rdata;
	assign PREADY = CE;
	assign PSLVERR = slverr & PSEL & PENABLE;
endmodule

// >>> logic/mcpie_pkg.sv
// Purpose: shared constants for the control and port input execute slice
// Assumes: 10-bit instruction words, 4-bit accumulator, APB register access
// Notes: codes that are not fixed here are parameters of the top module
package mcpie_pkg;
	// ==========================================================
	// instruction words
	localparam int INSTR_W = 10;
	localparam logic [9:0] OP_IRQ_UNMASK = 10'h005;
	localparam logic [9:0] OP_WDT_STOP_ARM = 10'h29c;
	localparam logic [9:0] OP_PD_ARM = 10'h05b;
	localparam logic [9:0] OP_READ_PIN_BIT = 10'h26f;
	localparam logic [9:0] OP_READ_PORT_ZERO = 10'h260;
	localparam logic [9:0] OP_READ_PORT_ONE = 10'h261;
	localparam logic [9:0] OP_READ_PORT_TWO = 10'h262;
	// default codes for words not fixed above
	localparam logic [9:0] DEF_IRQ_MASK = 10'h004;
	localparam logic [9:0] DEF_WDT_KICK = 10'h0a0;
	localparam logic [9:0] DEF_PD = 10'h002;
	localparam logic [9:0] DEF_DEEP_PD = 10'h008;

	// ==========================================================
	// widths
	localparam int ACC_W = 4;
	localparam int NIB_W = 4;
	localparam int TWO_W = 2;
	localparam int SYNC_W = 1 + NIB_W + NIB_W + TWO_W;
	localparam int ADDR_W = 8;

	// ==========================================================
	// register map, byte addresses
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_ACC = 8'h04;
	localparam logic [7:0] REG_CTRL = 8'h08;

	// status fields
	localparam int ST_GATE = 0;
	localparam int ST_ACCEPT = 1;
	localparam int ST_WDT_PERMIT = 2;
	localparam int ST_WDT_HALT = 3;
	localparam int ST_PD_ARMED = 4;

	// control fields
	localparam int CT_EXEC_EN = 0;
	localparam int CT_WDT_RESUME = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;
endpackage

// >>> logic/mcpie_sync.sv
// Purpose: two-stage synchroniser for the input port pins
// Assumes: pins are asynchronous to CLK
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
module mcpie_sync #(
	parameter int WIDTH = 11
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	// ==========================================================
	// per-bit double flop
	genvar i;
	generate
		if (WIDTH < 1) begin : g_chk
			$error("mcpie_sync WIDTH must be at least 1");
		end
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic stage1;
			logic stage2;
			logic next_stage1;
			logic next_stage2;
			always_comb begin
				next_stage1 = stage1;
				next_stage2 = stage2;
				if (ce) begin
					next_stage1 = din[i];
					next_stage2 = stage1;
				end
			end
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					stage1 <= 1'b0;
					stage2 <= 1'b0;
				end else begin
					stage1 <= next_stage1;
					stage2 <= next_stage2;
				end
			end
			assign dout[i] = stage2;
		end
	endgenerate
endmodule

// >>> test/mcpie_monitor.sv
// Purpose: concurrent checks on the execute slice ports
// Assumes: pins steady around port reads; exec enable seen on APB writes
// Notes: pin reads pass a two-flop synchroniser, hence past depth 3
`timescale 1ns/1ps
module mcpie_monitor (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic INSTR_VALID,
	input wire logic [9:0] INSTR,
	input wire logic PIN_BIT,
	input wire logic [1:0] TWO_BIT_PORT,
	input wire logic [3:0] ACC,
	input wire logic ACC_LOAD,
	input wire logic IRQ_GLOBAL_GATE,
	input wire logic IRQ_ACCEPT,
	input wire logic WDT_STOP_PERMIT,
	input wire logic WDT_HALT,
	input wire logic WDT_RESTART,
	input wire logic PD_REQ,
	input wire logic DEEP_PD_REQ,
	input wire logic INSTR_DONE,
	input wire logic CARRY_WE,
	input wire logic SKIP_NEXT,
	input wire logic PREADY,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA
);
	// ==========================================================
	// reference state
	// exec enable and the arm are tracked here, since idle cycles
	// may carry any word without spending the arm
	logic en_m;
	logic armed_m;
	logic ex;
	logic pd_ok;
	logic deep_ok;
	assign ex = CE && INSTR_VALID && en_m;
	assign pd_ok = ex && INSTR == mcpie_pkg::DEF_PD && armed_m;
	assign deep_ok = ex && INSTR == mcpie_pkg::DEF_DEEP_PD && armed_m;
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			en_m <= mcpie_pkg::CTRL_RESET[mcpie_pkg::CT_EXEC_EN];
			armed_m <= 1'b0;
		end else begin
			if (CE && PSEL && PENABLE && PWRITE &&
				PADDR == mcpie_pkg::REG_CTRL) begin
				en_m <= PWDATA[mcpie_pkg::CT_EXEC_EN];
			end
			if (ex) begin
				armed_m <= INSTR == mcpie_pkg::OP_PD_ARM;
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	mask_gate_a: assert property (
		ex && INSTR == mcpie_pkg::DEF_IRQ_MASK
		|=> !IRQ_GLOBAL_GATE && INSTR_DONE)
		else $error("mask kept gate");
	unmask_gate_a: assert property (
		ex && INSTR == mcpie_pkg::OP_IRQ_UNMASK
		|=> IRQ_GLOBAL_GATE && INSTR_DONE)
		else $error("unmask missed gate");
	accept_lag_a: assert property (
		CE |=> IRQ_ACCEPT == $past(IRQ_GLOBAL_GATE))
		else $error("accept not one cycle behind gate");
	stop_arm_a: assert property (
		ex && INSTR == mcpie_pkg::OP_WDT_STOP_ARM
		|=> WDT_STOP_PERMIT && !WDT_RESTART)
		else $error("stop arm wrong");
	kick_halt_a: assert property (
		ex && INSTR == mcpie_pkg::DEF_WDT_KICK && WDT_STOP_PERMIT
		|=> WDT_HALT && !WDT_STOP_PERMIT && !WDT_RESTART)
		else $error("permitted kick did not halt");
	kick_restart_a: assert property (
		ex && INSTR == mcpie_pkg::DEF_WDT_KICK && !WDT_STOP_PERMIT &&
		!WDT_HALT |=> WDT_RESTART && !WDT_HALT)
		else $error("plain kick did not restart");
	pd_only_a: assert property (
		$rose(PD_REQ) |-> $past(pd_ok))
		else $error("pd without arm");
	deep_only_a: assert property (
		$rose(DEEP_PD_REQ) |-> $past(deep_ok))
		else $error("deep pd without arm");
	pd_go_a: assert property (
		ex && INSTR == mcpie_pkg::OP_PD_ARM ##1
		ex && INSTR == mcpie_pkg::DEF_PD |=> PD_REQ)
		else $error("armed pd lost");
	deep_go_a: assert property (
		ex && INSTR == mcpie_pkg::OP_PD_ARM ##1
		ex && INSTR == mcpie_pkg::DEF_DEEP_PD
		|=> DEEP_PD_REQ && !PD_REQ)
		else $error("armed deep pd lost");
	pin_bit_a: assert property (
		ex && INSTR == mcpie_pkg::OP_READ_PIN_BIT
		|=> ACC == {3'h0, $past(PIN_BIT, 3)} && ACC_LOAD)
		else $error("pin bit read");
	port_two_a: assert property (
		ex && INSTR == mcpie_pkg::OP_READ_PORT_TWO
		|=> ACC == {2'h0, $past(TWO_BIT_PORT, 3)} && ACC_LOAD)
		else $error("port two read");
	no_side_a: assert property (
		!CARRY_WE && !SKIP_NEXT && PREADY == CE)
		else $error("carry, skip or ready wrong");
endmodule
bind mcpie_exec mcpie_monitor i_mcpie_monitor (.*);

// >>> test/mcpie_pins.sv
// Purpose: model of the external input port pins
// Assumes: the bench chooses the levels
// Notes: pins change just after an edge, the design must resynchronise
`timescale 1ns/1ps
module mcpie_pins (
	input wire logic clk,
	input wire logic [10:0] level,
	output logic [10:0] pins
);
	// ==========================================================
	// pin drive
	always_ff @(posedge clk) begin
		pins <= level;
	end
endmodule

// >>> test/testbench.sv
// Purpose: self-checking bench for the execute slice
// Assumes: exec enable is cleared over APB only for one short scenario
// Notes: pin levels are all ones, then all zeros, then random from a fixed seed
`timescale 1ns/1ps
module testbench;
	// ==========================================================
	// signals
	logic CLK = 0, RST_N = 0, CE = 1, INSTR_VALID = 0;
	logic [9:0] INSTR = 10'h000;
	logic PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA, r, tmp;
	logic PIN_BIT, ACC_LOAD, IRQ_GLOBAL_GATE, IRQ_ACCEPT, e;
	logic WDT_STOP_PERMIT, WDT_HALT, WDT_RESTART, PD_REQ, DEEP_PD_REQ;
	logic INSTR_DONE, CARRY_WE, SKIP_NEXT;
	logic [3:0] FIRST_NIBBLE_PORT, SECOND_NIBBLE_PORT, ACC;
	logic [1:0] TWO_BIT_PORT;
	logic [10:0] lv = 11'h000, pins;
	logic [9:0] op;
	logic [9:0] ops [4] = '{mcpie_pkg::OP_READ_PIN_BIT,
		mcpie_pkg::OP_READ_PORT_ZERO, mcpie_pkg::OP_READ_PORT_ONE,
		mcpie_pkg::OP_READ_PORT_TWO};
	int fails = 0, n_checks = 0, cyc = 0, n_pd = 0, n_deep = 0;
	int seed = 32'h85ac9a31;
	assign {PIN_BIT, FIRST_NIBBLE_PORT, SECOND_NIBBLE_PORT, TWO_BIT_PORT} = pins;
	mcpie_exec i_mcpie_exec (.*);
	mcpie_pins i_mcpie_pins (.clk(CLK), .level(lv), .pins(pins));
	always #5 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc++;
		n_pd += (PD_REQ === 1'b1);
		n_deep += (DEEP_PD_REQ === 1'b1);
		if (cyc == 3000) begin
			fails++;
			give_verdict();
		end
	end
	// ==========================================================
	// tasks
	function automatic logic [3:0] exp_acc(logic [9:0] o, logic [10:0] p);
		case (o)
			mcpie_pkg::OP_READ_PIN_BIT: return {3'h0, p[10]};
			mcpie_pkg::OP_READ_PORT_ZERO: return p[9:6];
			mcpie_pkg::OP_READ_PORT_ONE: return p[5:2];
			default: return {2'h0, p[1:0]};
		endcase
	endfunction
	task automatic chk(input logic [31:0] seen, exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic issue(input logic [9:0] o);
		@(posedge CLK);
		INSTR <= o;
		INSTR_VALID <= 1'b1;
	endtask
	// the last word executes at this edge, outputs looked at just after
	task automatic settle();
		@(posedge CLK);
		INSTR_VALID <= 1'b0;
		#1;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		// only the bench timeout ends a wait for ready
		do begin
			@(posedge CLK);
		end while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	initial begin
		repeat (16) @(posedge CLK);
		RST_N <= 1'b1;
		#1;
		chk({ACC, IRQ_GLOBAL_GATE, IRQ_ACCEPT}, 32'h0, "reset state");
		issue(mcpie_pkg::OP_IRQ_UNMASK);
		settle();
		chk({IRQ_GLOBAL_GATE, IRQ_ACCEPT}, 32'h2, "accept lag");
		@(posedge CLK);
		#1;
		chk(IRQ_ACCEPT, 32'h1, "accept on");
		issue(mcpie_pkg::DEF_IRQ_MASK);
		settle();
		chk({IRQ_GLOBAL_GATE, IRQ_ACCEPT, INSTR_DONE}, 32'h3, "gate off");
		issue(mcpie_pkg::DEF_WDT_KICK);
		settle();
		chk({WDT_RESTART, WDT_HALT}, 32'h2, "plain kick");
		issue(mcpie_pkg::OP_WDT_STOP_ARM);
		issue(mcpie_pkg::DEF_WDT_KICK);
		settle();
		chk({WDT_HALT, WDT_STOP_PERMIT, WDT_RESTART}, 32'h4, "halt");
		apb(1'b0, mcpie_pkg::REG_STATUS, 32'h0);
		chk(r & 32'h1f, 32'h8, "status halt");
		apb(1'b1, mcpie_pkg::REG_CTRL, 32'h3);
		apb(1'b0, mcpie_pkg::REG_STATUS, 32'h0);
		chk(r & 32'h1f, 32'h0, "status resumed");
		apb(1'b0, 8'h0c, 32'h0);
		chk(r, 32'h0, "unmapped data");
		chk(e, 32'h1, "unmapped error");
		// words are ignored while exec enable is clear
		apb(1'b1, mcpie_pkg::REG_CTRL, 32'h0);
		issue(mcpie_pkg::OP_IRQ_UNMASK);
		settle();
		chk({IRQ_GLOBAL_GATE, INSTR_DONE}, 32'h0, "exec held off");
		apb(1'b1, mcpie_pkg::REG_CTRL, 32'h1);
		// back to back: an unknown word or any other word spends the arm
		issue(mcpie_pkg::OP_PD_ARM);
		issue(mcpie_pkg::DEF_PD);
		issue(mcpie_pkg::OP_PD_ARM);
		issue(10'h3ff);
		issue(mcpie_pkg::DEF_PD);
		issue(mcpie_pkg::DEF_DEEP_PD);
		issue(mcpie_pkg::OP_PD_ARM);
		issue(mcpie_pkg::DEF_DEEP_PD);
		settle();
		issue(mcpie_pkg::OP_PD_ARM);
		settle();
		issue(mcpie_pkg::DEF_PD);
		settle();
		repeat (2) @(posedge CLK);
		chk(n_pd, 32'h2, "pd pulses");
		chk(n_deep, 32'h1, "deep pd pulses");
		for (int i = 0; i < 32; i++) begin
			@(posedge CLK);
			tmp = $random(seed);
			lv <= (i < 4) ? 11'h7ff : (i < 8) ? 11'h000 : tmp[10:0];
			op = ops[i % 4];
			repeat (4) @(posedge CLK);
			issue(op);
			settle();
			chk(ACC, exp_acc(op, lv), "acc");
			chk({ACC_LOAD, CARRY_WE, SKIP_NEXT}, 32'h4, "load");
		end
		give_verdict();
	end
endmodule
